// File: design/vbc_regs.sv
// video output and blanking control registers behind a two-wire serial slave
`timescale 1ns/1ps

module vbc_regs
   import vbc_pkg::*;
#(
   // device address on the serial bus, arbitrary value
   parameter logic [6:0] DEV_ADDR = 7'h2A
) (
   // clock and resets
   input wire logic clk,
   input wire logic rstn,
   input wire logic power_down_n,
   // serial bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // monitor inputs
   input wire logic auto_startup,
   input wire logic vcr_sb_is_output,
   input wire vbc_pkg::vbc_code_t vcr_sb_level_code,
   input wire logic vcr_fb_in,
   // video controls
   output logic tv_fast_blank_out_en,
   output logic vcr_chroma_out_en,
   output logic vcr_chroma_gnd,
   output logic [4:0] video_out_en,
   output logic [3:0] rgb_gain_sel,
   output logic [2:0] dc_restore_src_sel,
   output logic [3:0] clamp_ctrl,
   // blanking controls
   output logic tv_fast_blank_level,
   output logic [2:0] tv_slow_blank_level,
   output logic [2:0] vcr_slow_blank_level,
   output logic [1:0] slow_blank_direction,
   // interrupt
   output logic int_n
);
   import vbc_pkg::*;

   // ----------------------------------------------------------------
   // serial slave
   // ----------------------------------------------------------------
   vbc_state_e state_reg, state_next;
   logic [7:0] shift_reg, shift_next;
   logic [3:0] cnt_reg, cnt_next;
   vbc_addr_t ptr_reg, ptr_next;
   logic rw_reg, rw_next;
   logic mack_reg, mack_next;
   logic scl_reg, scl_next;
   logic sda_reg, sda_next;
   logic scl_rise, scl_fall, start_cond, stop_cond;
   logic wr_stb, rd_load;
   logic [7:0] rd_data;
   vbc_addr_t ptr_inc;

   logic [7:0] oe_reg, oe_next;
   logic [7:0] gain_reg, gain_next;
   logic [7:0] blank_reg, blank_next;
   logic [7:0] mask_reg, mask_next;
   vbc_code_t svcr_reg, svcr_next;
   logic vcr_fast_blank_status_reg, vcr_fast_blank_status_next;
   logic pend_reg, pend_next;

   assign scl_rise = scl_in & ~scl_reg;
   assign scl_fall = ~scl_in & scl_reg;
   assign start_cond = scl_in & scl_reg & sda_reg & ~sda_in;
   assign stop_cond = scl_in & scl_reg & ~sda_reg & sda_in;
   assign ptr_inc = (ptr_reg == REG_LAST) ? REG_FIRST : ptr_reg + ADDR_ONE;

   always_comb begin
      unique case (ptr_reg)
         REG_OUT_EN: rd_data = oe_reg;
         REG_GAIN: rd_data = gain_reg;
         REG_BLANK: rd_data = blank_reg;
         REG_MON: rd_data = {5'h00, vcr_fast_blank_status_reg, svcr_reg};
         REG_MASK: rd_data = mask_reg;
         default: rd_data = BYTE_ZERO;
      endcase
   end

   always_comb begin
      state_next = state_reg;
      shift_next = shift_reg;
      cnt_next = cnt_reg;
      ptr_next = ptr_reg;
      rw_next = rw_reg;
      mack_next = mack_reg;
      scl_next = scl_in;
      sda_next = sda_in;
      wr_stb = 1'b0;
      rd_load = 1'b0;
      if (start_cond) begin
         state_next = VBC_ADDR;
         cnt_next = CNT_ZERO;
      end else if (stop_cond) begin
         state_next = VBC_IDLE;
      end else if (scl_rise) begin
         if (state_reg == VBC_ADDR || state_reg == VBC_PTR || state_reg == VBC_WDAT) begin
            shift_next = {shift_reg[6:0], sda_in};
            cnt_next = cnt_reg + CNT_ONE;
         end else if (state_reg == VBC_RACK) begin
            mack_next = ~sda_in;
         end
      end else if (scl_fall) begin
         unique case (state_reg)
            VBC_IDLE: ;
            VBC_ADDR: if (cnt_reg == BITS_PER_BYTE) begin
               rw_next = shift_reg[0];
               cnt_next = CNT_ZERO;
               state_next = (shift_reg[7:1] == DEV_ADDR) ? VBC_AACK : VBC_IDLE;
            end
            VBC_AACK: begin
               cnt_next = CNT_ZERO;
               if (rw_reg) begin
                  rd_load = 1'b1;
                  shift_next = rd_data;
                  ptr_next = ptr_inc;
                  state_next = VBC_RDAT;
               end else begin
                  state_next = VBC_PTR;
               end
            end
            VBC_PTR: if (cnt_reg == BITS_PER_BYTE) begin
               ptr_next = shift_reg[3:0];
               state_next = VBC_PACK;
            end
            VBC_PACK: begin
               cnt_next = CNT_ZERO;
               state_next = VBC_WDAT;
            end
            VBC_WDAT: if (cnt_reg == BITS_PER_BYTE) begin
               wr_stb = 1'b1;
               ptr_next = ptr_inc;
               state_next = VBC_PACK;
            end
            VBC_RDAT: begin
               if (cnt_reg == BIT_LAST) begin
                  state_next = VBC_RACK;
               end else begin
                  shift_next = {shift_reg[6:0], 1'b0};
                  cnt_next = cnt_reg + CNT_ONE;
               end
            end
            VBC_RACK: begin
               cnt_next = CNT_ZERO;
               if (mack_reg) begin
                  rd_load = 1'b1;
                  shift_next = rd_data;
                  ptr_next = ptr_inc;
                  state_next = VBC_RDAT;
               end else begin
                  state_next = VBC_IDLE;
               end
            end
         endcase
      end
      if (!power_down_n) begin
         state_next = VBC_IDLE;
         cnt_next = CNT_ZERO;
         ptr_next = REG_FIRST;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= VBC_IDLE;
         shift_reg <= BYTE_ZERO;
         cnt_reg <= CNT_ZERO;
         ptr_reg <= REG_FIRST;
         rw_reg <= 1'b0;
         mack_reg <= 1'b0;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         cnt_reg <= cnt_next;
         ptr_reg <= ptr_next;
         rw_reg <= rw_next;
         mack_reg <= mack_next;
         scl_reg <= scl_next;
         sda_reg <= sda_next;
      end
   end

   // pin is only ever pulled low
   assign sda_out = 1'b0;
   assign sda_oe = (state_reg == VBC_AACK) || (state_reg == VBC_PACK) ||
                   ((state_reg == VBC_RDAT) && !shift_reg[7]);

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_comb begin
      oe_next = oe_reg;
      gain_next = gain_reg;
      blank_next = blank_reg;
      mask_next = mask_reg;
      if (wr_stb) begin
         unique case (ptr_reg)
            REG_OUT_EN: oe_next = shift_reg;
            REG_GAIN: gain_next = shift_reg;
            REG_BLANK: blank_next = shift_reg;
            REG_MASK: mask_next = shift_reg & MASK_WBITS;
            default: ;
         endcase
      end
      if (!power_down_n) begin
         oe_next = OUT_EN_RST;
         gain_next = GAIN_RST;
         blank_next = BLANK_RST;
         mask_next = MASK_RST;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         oe_reg <= OUT_EN_RST;
         gain_reg <= GAIN_RST;
         blank_reg <= BLANK_RST;
         mask_reg <= MASK_RST;
      end else begin
         oe_reg <= oe_next;
         gain_reg <= gain_next;
         blank_reg <= blank_next;
         mask_reg <= mask_next;
      end
   end

   // ----------------------------------------------------------------
   // monitor and interrupt
   // ----------------------------------------------------------------
   always_comb begin
      svcr_next = vcr_sb_is_output ? svcr_reg : vcr_sb_level_code;
      vcr_fast_blank_status_next = oe_reg[OE_TV_FAST_BLANK_OUT_EN] ? vcr_fb_in : vcr_fast_blank_status_reg;
      // a new change wins over the clear by a monitor read
      pend_next = (pend_reg && !(rd_load && ptr_reg == REG_MON)) ||
                  ((svcr_next != svcr_reg) && !mask_reg[MK_SVCR]) ||
                  ((vcr_fast_blank_status_next != vcr_fast_blank_status_reg) && !mask_reg[MK_VCR_FAST_BLANK_STATUS]);
      if (!power_down_n) begin
         svcr_next = CODE_ZERO;
         vcr_fast_blank_status_next = 1'b0;
         pend_next = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         svcr_reg <= CODE_ZERO;
         vcr_fast_blank_status_reg <= 1'b0;
         pend_reg <= 1'b0;
      end else begin
         svcr_reg <= svcr_next;
         vcr_fast_blank_status_reg <= vcr_fast_blank_status_next;
         pend_reg <= pend_next;
      end
   end

   assign int_n = ~pend_reg;

   // ----------------------------------------------------------------
   // decoded outputs
   // ----------------------------------------------------------------
   logic [25:0] dec_reg, dec_next;
   vbc_code_t src_code;

   always_comb begin
      src_code = auto_startup ? SRC_VCR : gain_reg[GN_SRC_LSB +: 2];
      dec_next[0] = oe_reg[OE_TV_FAST_BLANK_OUT_EN];
      dec_next[1] = oe_reg[OE_VCR_CHROMA_OUT_EN] && !oe_reg[OE_CIO];
      dec_next[2] = oe_reg[OE_CIO];
      dec_next[7:3] = oe_reg[OE_VID_MSB:0];
      dec_next[11:8] = {gain_reg[GN_VOL_LSB +: 2] == GAIN_9DB1,
                        gain_reg[GN_VOL_LSB +: 2] == GAIN_8DB2,
                        gain_reg[GN_VOL_LSB +: 2] == GAIN_7DB2,
                        gain_reg[GN_VOL_LSB +: 2] == GAIN_6DB};
      dec_next[14:12] = {src_code == SRC_VCR, src_code == SRC_ENC_LUMA,
                         src_code == SRC_ENC_CVBS};
      dec_next[18:15] = {gain_reg[GN_CLAMPB], gain_reg[GN_CLAMP_MSB:GN_CLAMP_LSB]};
      dec_next[19] = (blank_reg[BL_FB_LSB +: 2] == FB_4V) ||
                     ((blank_reg[BL_FB_LSB +: 2] == FB_FOLLOW) && vcr_fb_in);
      dec_next[22:20] = {blank_reg[BL_SBT_LSB +: 2] == SB_HIGH,
                         blank_reg[BL_SBT_LSB +: 2] == SB_MID,
                         blank_reg[BL_SBT_LSB +: 2] == SB_LOW};
      dec_next[25:23] = {blank_reg[BL_SBV_LSB +: 2] == SB_HIGH,
                         blank_reg[BL_SBV_LSB +: 2] == SB_MID,
                         blank_reg[BL_SBV_LSB +: 2] == SB_LOW};
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dec_reg <= 26'h0000000;
      end else begin
         dec_reg <= dec_next;
      end
   end

   assign tv_fast_blank_out_en = dec_reg[0];
   assign vcr_chroma_out_en = dec_reg[1];
   assign vcr_chroma_gnd = dec_reg[2];
   assign video_out_en = dec_reg[7:3];
   assign rgb_gain_sel = dec_reg[11:8];
   assign dc_restore_src_sel = dec_reg[14:12];
   assign clamp_ctrl = dec_reg[18:15];
   assign tv_fast_blank_level = dec_reg[19];
   assign tv_slow_blank_level = dec_reg[22:20];
   assign vcr_slow_blank_level = dec_reg[25:23];
   assign slow_blank_direction = blank_reg[BL_SBIO_LSB +: 2];

endmodule

// File: design/vbc_pkg.sv
// shared constants for the video blanking control register bank
package vbc_pkg;
   typedef logic [3:0] vbc_addr_t;
   typedef logic [1:0] vbc_code_t;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam vbc_addr_t REG_FIRST = 4'h0;
   localparam vbc_addr_t REG_OUT_EN = 4'h5;
   localparam vbc_addr_t REG_GAIN = 4'h6;
   localparam vbc_addr_t REG_BLANK = 4'h7;
   localparam vbc_addr_t REG_MON = 4'h8;
   localparam vbc_addr_t REG_MASK = 4'h9;
   localparam vbc_addr_t REG_LAST = 4'h9;
   localparam vbc_addr_t ADDR_ONE = 4'h1;

   // ----------------------------------------------------------------
   // reset values and writable bits
   // ----------------------------------------------------------------
   localparam logic [7:0] OUT_EN_RST = 8'h00;
   localparam logic [7:0] GAIN_RST = 8'h04;
   localparam logic [7:0] BLANK_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h08;
   localparam logic [7:0] MASK_WBITS = 8'h9E;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam vbc_code_t CODE_ZERO = 2'h0;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int OE_CIO = 7;
   localparam int OE_TV_FAST_BLANK_OUT_EN = 6;
   localparam int OE_VCR_CHROMA_OUT_EN = 5;
   localparam int OE_VID_MSB = 4;
   localparam int GN_VOL_LSB = 0;
   localparam int GN_CLAMP_LSB = 2;
   localparam int GN_CLAMP_MSB = 4;
   localparam int GN_SRC_LSB = 5;
   localparam int GN_CLAMPB = 7;
   localparam int BL_FB_LSB = 0;
   localparam int BL_SBT_LSB = 2;
   localparam int BL_SBV_LSB = 4;
   localparam int BL_SBIO_LSB = 6;
   localparam int MK_SVCR = 1;
   localparam int MK_VCR_FAST_BLANK_STATUS = 2;

   // ----------------------------------------------------------------
   // field codes
   // ----------------------------------------------------------------
   localparam vbc_code_t GAIN_6DB = 2'h0;
   localparam vbc_code_t GAIN_7DB2 = 2'h1;
   localparam vbc_code_t GAIN_8DB2 = 2'h2;
   localparam vbc_code_t GAIN_9DB1 = 2'h3;
   localparam vbc_code_t SRC_ENC_CVBS = 2'h0;
   localparam vbc_code_t SRC_ENC_LUMA = 2'h1;
   localparam vbc_code_t SRC_VCR = 2'h2;
   localparam vbc_code_t FB_0V = 2'h0;
   localparam vbc_code_t FB_4V = 2'h1;
   localparam vbc_code_t FB_FOLLOW = 2'h2;
   localparam vbc_code_t SB_LOW = 2'h0;
   localparam vbc_code_t SB_MID = 2'h1;
   localparam vbc_code_t SB_HIGH = 2'h3;

   // ----------------------------------------------------------------
   // serial link
   // ----------------------------------------------------------------
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;

   typedef enum logic [2:0] {
      VBC_IDLE = 3'h0,
      VBC_ADDR = 3'h1,
      VBC_AACK = 3'h3,
      VBC_PTR = 3'h2,
      VBC_PACK = 3'h6,
      VBC_WDAT = 3'h7,
      VBC_RDAT = 3'h5,
      VBC_RACK = 3'h4
   } vbc_state_e;
endpackage

// File: verif/vbc_regs_props.sv
// assertion checker for the video blanking control register bank
`timescale 1ns/1ps

module vbc_regs_props
   import vbc_pkg::*;
(
   // clock and resets
   input wire logic clk,
   input wire logic rstn,
   input wire logic power_down_n,
   // serial bus
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_oe,
   // monitor inputs
   input wire logic auto_startup,
   input wire logic vcr_sb_is_output,
   input wire vbc_pkg::vbc_code_t vcr_sb_level_code,
   input wire logic vcr_fb_in,
   // decoded controls
   input wire logic tv_fast_blank_out_en,
   input wire logic vcr_chroma_out_en,
   input wire logic vcr_chroma_gnd,
   input wire logic [3:0] rgb_gain_sel,
   input wire logic [2:0] dc_restore_src_sel,
   input wire logic [2:0] tv_slow_blank_level,
   input wire logic [2:0] vcr_slow_blank_level,
   input wire logic [1:0] slow_blank_direction,
   input wire logic int_n
);
   logic [6:0] act_reg, act_next;
   logic [7:0] quiet_reg, quiet_next;

   // ----------------------------------------------------------------
   // cycles since any activity able to move the monitor
   // ----------------------------------------------------------------
   always_comb begin
      act_next = {power_down_n, scl_in, sda_in, vcr_sb_is_output, vcr_sb_level_code, vcr_fb_in};
      quiet_next = quiet_reg + ((quiet_reg != 8'hFF) ? 8'h01 : 8'h00);
      if (act_next != act_reg) begin
         quiet_next = 8'h00;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         act_reg <= 7'h00;
         quiet_reg <= 8'h00;
      end else begin
         act_reg <= act_next;
         quiet_reg <= quiet_next;
      end
   end

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_chroma_gnd_excl: assert property (vcr_chroma_gnd |-> !vcr_chroma_out_en)
      else $error("chroma pin grounded and enabled together");
   a_gain_one_hot: assert property ($past(rstn) |-> $onehot(rgb_gain_sel))
      else $error("gain select not one-hot");
   a_src_at_most: assert property ($onehot0(dc_restore_src_sel))
      else $error("several restore sources selected");
   a_auto_forces_vcr: assert property ($past(auto_startup) && $past(rstn) |->
      dc_restore_src_sel == 3'b100)
      else $error("automatic startup did not force vcr source");
   a_slow_levels_valid: assert property ($onehot0(tv_slow_blank_level) &&
      $onehot0(vcr_slow_blank_level))
      else $error("slow blanking level not one-hot");
   a_pd_quiets_pins: assert property (!power_down_n |=> int_n && !sda_oe)
      else $error("power-down left interrupt or data pin active");
   a_pd_defaults_out: assert property (!power_down_n [*2] |=> rgb_gain_sel == 4'b0001 &&
      tv_slow_blank_level == 3'b001 && vcr_slow_blank_level == 3'b001 &&
      !tv_fast_blank_out_en && slow_blank_direction == 2'b00)
      else $error("outputs not at defaults during power-down");
   a_oe_moves_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data pin changed while clock high");
   a_int_has_cause: assert property ($fell(int_n) |-> quiet_reg < 8'h08)
      else $error("interrupt with no recent cause");

   c_int_fell: cover property ($fell(int_n));
   c_ack_given: cover property ($rose(sda_oe));
   c_pd_pulse: cover property (!power_down_n ##1 power_down_n);
   c_auto_src: cover property (auto_startup ##1 dc_restore_src_sel == 3'b100);
endmodule

bind vbc_regs vbc_regs_props u_props (
   .clk(clk), .rstn(rstn), .power_down_n(power_down_n), .scl_in(scl_in), .sda_in(sda_in),
   .sda_oe(sda_oe), .auto_startup(auto_startup), .vcr_sb_is_output(vcr_sb_is_output),
   .vcr_sb_level_code(vcr_sb_level_code), .vcr_fb_in(vcr_fb_in),
   .tv_fast_blank_out_en(tv_fast_blank_out_en), .vcr_chroma_out_en(vcr_chroma_out_en),
   .vcr_chroma_gnd(vcr_chroma_gnd), .rgb_gain_sel(rgb_gain_sel),
   .dc_restore_src_sel(dc_restore_src_sel), .tv_slow_blank_level(tv_slow_blank_level),
   .vcr_slow_blank_level(vcr_slow_blank_level), .slow_blank_direction(slow_blank_direction),
   .int_n(int_n));

// File: verif/vbc_host.sv
// two-wire bus host model for the register bank
`timescale 1ns/1ps

module vbc_host (
   // clock
   input wire logic clk,
   // bus wires
   input wire logic dev_pull,
   output logic scl,
   output logic sda
);
   logic host_pull;

   // released wire floats high through the pull-up
   assign sda = ~(host_pull | dev_pull);

   initial begin
      scl = 1'b1;
      host_pull = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // also serves as repeated start
   task automatic start();
      host_pull = 1'b0;
      tick(2);
      scl = 1'b1;
      tick(4);
      host_pull = 1'b1;
      tick(4);
      scl = 1'b0;
   endtask

   task automatic stop();
      tick(2);
      host_pull = 1'b1;
      tick(2);
      scl = 1'b1;
      tick(4);
      host_pull = 1'b0;
      tick(4);
   endtask

   // data moves only well after scl falls, never near a start or stop
   task automatic bit_io(input logic b, output logic r);
      tick(2);
      host_pull = ~b;
      tick(2);
      scl = 1'b1;
      tick(2);
      r = sda;
      tick(2);
      scl = 1'b0;
   endtask

   // msb first, ninth slot is the acknowledge
   task automatic byte_io(input logic [7:0] d, input logic mack, output logic [7:0] q,
      output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(mack, ack);
   endtask
endmodule

// File: verif/vbc_regs_tb.sv
// self-checking bench for the video blanking control register bank
`timescale 1ns/1ps

module vbc_regs_tb;
   import vbc_pkg::*;
   localparam logic [6:0] DEV = 7'h2A;
   logic clk, rstn, power_down_n, auto_startup, vcr_sb_is_output, vcr_fb_in;
   vbc_code_t vcr_sb_level_code;
   logic scl, sda, sda_oe, sda_out, int_n, tv_fast_blank_level;
   logic [4:0] video_out_en;
   logic [3:0] clamp_ctrl;
   logic tv_fast_blank_out_en, vcr_chroma_out_en, vcr_chroma_gnd;
   logic [3:0] rgb_gain_sel;
   logic [2:0] dc_restore_src_sel, tv_slow_blank_level, vcr_slow_blank_level;
   logic [1:0] slow_blank_direction;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;

   always #4 clk = ~clk;

   vbc_regs #(.DEV_ADDR(DEV)) dut (.clk(clk), .rstn(rstn), .power_down_n(power_down_n),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .auto_startup(auto_startup), .vcr_sb_is_output(vcr_sb_is_output),
      .vcr_sb_level_code(vcr_sb_level_code), .vcr_fb_in(vcr_fb_in),
      .tv_fast_blank_out_en(tv_fast_blank_out_en), .vcr_chroma_out_en(vcr_chroma_out_en),
      .vcr_chroma_gnd(vcr_chroma_gnd), .video_out_en(video_out_en),
      .rgb_gain_sel(rgb_gain_sel), .dc_restore_src_sel(dc_restore_src_sel),
      .clamp_ctrl(clamp_ctrl), .tv_fast_blank_level(tv_fast_blank_level),
      .tv_slow_blank_level(tv_slow_blank_level), .vcr_slow_blank_level(vcr_slow_blank_level),
      .slow_blank_direction(slow_blank_direction), .int_n(int_n));

   vbc_host host (.clk(clk), .dev_pull(sda_oe), .scl(scl), .sda(sda));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input vbc_addr_t p, input logic [7:0] d[$]);
      logic [7:0] q;
      logic ack;
      host.start();
      host.byte_io({DEV, 1'b0}, 1'b1, q, ack);
      host.byte_io({4'h0, p}, 1'b1, q, ack);
      foreach (d[i]) begin
         host.byte_io(d[i], 1'b1, q, ack);
         chk(8'(ack), 8'h00);
      end
      host.stop();
      host.tick(4);
   endtask

   task automatic rd(input vbc_addr_t p, input logic [7:0] e[$]);
      logic [7:0] q;
      logic ack;
      host.start();
      host.byte_io({DEV, 1'b0}, 1'b1, q, ack);
      host.byte_io({4'h0, p}, 1'b1, q, ack);
      host.start();
      host.byte_io({DEV, 1'b1}, 1'b1, q, ack);
      foreach (e[i]) begin
         host.byte_io(8'hFF, i == e.size() - 1, q, ack);
         chk(q, e[i]);
      end
      host.stop();
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_enables();
      wr(REG_OUT_EN, '{8'hE0});
      chk(8'(tv_fast_blank_out_en), 8'h01);
      chk(8'({vcr_chroma_gnd, vcr_chroma_out_en}), 8'h02);
      wr(REG_OUT_EN, '{8'h20});
      chk(8'(tv_fast_blank_out_en), 8'h00);
      chk(8'({vcr_chroma_gnd, vcr_chroma_out_en}), 8'h01);
   endtask

   task automatic t_decode();
      logic [1:0] c2;
      logic [2:0] sb [4] = '{3'b001, 3'b010, 3'b000, 3'b100};
      vcr_fb_in = 1'b1;
      for (int c = 0; c < 4; c++) begin
         c2 = 2'(c);
         wr(REG_GAIN, '{{1'b0, c2, 3'b000, c2}, {c2, c2, c2, c2}});
         chk(8'(rgb_gain_sel), 8'h01 << c);
         chk(8'(dc_restore_src_sel), (c == 3) ? 8'h00 : 8'h01 << c);
         chk(8'(tv_slow_blank_level), 8'(sb[c]));
         chk(8'(vcr_slow_blank_level), 8'(sb[c]));
         chk(8'(tv_fast_blank_level), 8'(c == 1 || c == 2));
         chk(8'(slow_blank_direction), 8'(c2));
      end
      auto_startup = 1'b1;
      host.tick(4);
      chk(8'(dc_restore_src_sel), 8'h04);
      auto_startup = 1'b0;
      vcr_fb_in = 1'b0;
   endtask

   task automatic t_monitor();
      vcr_sb_level_code = SB_MID;
      host.tick(4);
      chk(8'(int_n), 8'h00);
      rd(REG_MON, '{8'h01});
      chk(8'(int_n), 8'h01);
      vcr_sb_is_output = 1'b1;
      vcr_sb_level_code = SB_HIGH;
      host.tick(4);
      chk(8'(int_n), 8'h01);
      rd(REG_MON, '{8'h01});
      vcr_sb_is_output = 1'b0;
      host.tick(4);
      chk(8'(int_n), 8'h00);
      rd(REG_MON, '{8'h03});
      wr(REG_MASK, '{8'h0A});
      vcr_sb_level_code = SB_LOW;
      vcr_fb_in = 1'b1;
      host.tick(4);
      chk(8'(int_n), 8'h01);
      rd(REG_MON, '{8'h00});
      wr(REG_OUT_EN, '{8'h40});
      chk(8'(int_n), 8'h00);
      rd(REG_MON, '{8'h04});
      wr(REG_MASK, '{8'hFF});
      vcr_fb_in = 1'b0;
      host.tick(4);
      chk(8'(int_n), 8'h01);
      wr(4'h2, '{8'hFF});
      rd(REG_MASK, '{8'h9E, 8'h00, 8'h00, 8'h00});
   endtask

   task automatic t_power_down();
      wr(REG_OUT_EN, '{8'hFF, 8'h7F, 8'hFF});
      chk(8'(video_out_en), 8'h1F);
      chk(8'(clamp_ctrl), 8'h07);
      power_down_n = 1'b0;
      host.tick(3);
      power_down_n = 1'b1;
      host.tick(3);
      chk(8'(slow_blank_direction), 8'h00);
      chk(8'(video_out_en), 8'h00);
      chk(8'(clamp_ctrl), 8'h01);
      rd(REG_OUT_EN, '{8'h00, 8'h04, 8'h00, 8'h00, 8'h08});
   endtask

   task automatic t_defaults();
      host.tick(4);
      chk(8'(rgb_gain_sel), 8'h01);
      chk(8'(dc_restore_src_sel), 8'h01);
      chk(8'(tv_slow_blank_level), 8'h01);
      chk(8'(sda_out), 8'h00);
      rd(REG_OUT_EN, '{8'h00, 8'h04, 8'h00, 8'h00, 8'h08});
   endtask

   task automatic print_verdict();
      $display("errors %0d, checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         num_errors++;
         print_verdict();
      end
   end

   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      power_down_n = 1'b1;
      auto_startup = 1'b0;
      vcr_sb_is_output = 1'b0;
      vcr_sb_level_code = SB_LOW;
      vcr_fb_in = 1'b0;
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      t_defaults();
      t_enables();
      t_decode();
      t_monitor();
      t_power_down();
      print_verdict();
   end
endmodule
